// ==== core/aas_defines.vh ====
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH
// channel count: 10 assigned plus spare ways
`define AAS_NCH          12
// byte addresses of the register words
`define AAS_A_CTRL       8'h00
`define AAS_A_POL        8'h04
`define AAS_A_STAT       8'h08
`define AAS_A_LAMP       8'h0C
`define AAS_A_IRQ_STAT   8'h10
`define AAS_A_IRQ_CLR    8'h14
`define AAS_A_IRQ_EN     8'h18
// control word fields
`define AAS_CTL_AUTO_BIT 0
`define AAS_CTL_PER_LSB  1
`define AAS_CTL_PER_MSB  3
`define AAS_CTL_RST_VAL  32'h0000_0002
// auto-accept period limits in minutes
`define AAS_PER_MIN      3'h1
`define AAS_PER_MAX      3'h5
// timing at 20 MHz
`define AAS_CLK_HZ       20000000
`define AAS_DEB_MS       500
`define AAS_FLASH_HZ     3
`define AAS_DEB_CYC      ((`AAS_CLK_HZ / 1000) * `AAS_DEB_MS)
`define AAS_HALF_CYC     (`AAS_CLK_HZ / (2 * `AAS_FLASH_HZ))
`define AAS_MIN_CYC      (`AAS_CLK_HZ * 60)
// axi response codes
`define AAS_RESP_OK      2'h0
`define AAS_RESP_ERR     2'h2
// irq event bits
`define AAS_EV_ALARM     0
`define AAS_EV_AUTO      1
`endif

// ==== core/aas_annunciator.v ====
// Behaviour
// R01 - new alarm sounds horn, flashes lamp
// R02 - flash toggle between two and five hertz
// R03 - accept silences horn, flashing becomes steady
// R04 - lamp off after healthy and reset
// R05 - further alarm resounds horn and flashes
// R06 - auto accept after one to five minutes
// R07 - acceptance state kept locally per instance
// R08 - test lights lamps, horn, no alarm state
// R09 - inputs must persist half second first
// R10 - per channel polarity selects alarm sense
// R11 - field contact held for whole alarm
// R12 - spare channels identical to assigned ones
// R13 - group lamp test forces group lamps
// R14 - horn is or; buttons synced, edge-detected; code edge-detects accept and reset only, test is used as a level
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`include "aas_defines.vh"
`default_nettype none
module aas_annunciator #(
    parameter [31:0] DEB_CYC  = `AAS_DEB_CYC,
    parameter [31:0] HALF_CYC = `AAS_HALF_CYC,
    parameter [31:0] MIN_CYC  = `AAS_MIN_CYC
) (
    input  wire                    clk_i,
    input  wire                    reset_i,
    input  wire                    ce_i,
    input  wire [`AAS_NCH-1:0]     contact_i,
    input  wire                    accept_pb_i,
    input  wire                    reset_pb_i,
    input  wire                    test_pb_i,
    input  wire [1:0]              group_test_i,
    output reg  [`AAS_NCH-1:0]     lamp_o,
    output reg                     horn_o,
    output reg                     irq_o,
    input  wire                    s_axi_awvalid,
    output reg                     s_axi_awready,
    input  wire [7:0]              s_axi_awaddr,
    input  wire                    s_axi_wvalid,
    output reg                     s_axi_wready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    output reg                     s_axi_bvalid,
    input  wire                    s_axi_bready,
    output reg  [1:0]              s_axi_bresp,
    input  wire                    s_axi_arvalid,
    output reg                     s_axi_arready,
    input  wire [7:0]              s_axi_araddr,
    output reg                     s_axi_rvalid,
    input  wire                    s_axi_rready,
    output reg  [31:0]             s_axi_rdata,
    output reg  [1:0]              s_axi_rresp
);
    localparam N    = `AAS_NCH;
    localparam HALF = N / 2;

    // per-channel state
    reg  [31:0]  deb_cnt_ff [0:N-1];   // persistence counters
    reg  [N-1:0] alarm_ff;             // debounced alarm level
    reg  [N-1:0] unack_ff;             // flashing, not yet accepted
    reg  [N-1:0] latched_ff;           // lit until healthy and reset
    reg  [N-1:0] raw_ff;               // sampled contacts
    // pushbutton synchronisers
    reg  [2:0]   acc_sy_ff;
    reg  [2:0]   rst_sy_ff;
    reg  [1:0]   tst_sy_ff;
    reg  [3:0]   grp_sy_ff;
    // timers
    reg  [31:0]  flash_cnt_ff;
    reg          flash_ff;
    reg  [31:0]  auto_cnt_ff;
    reg  [2:0]   auto_min_ff;
    // registers
    reg  [31:0]  ctrl_ff;
    reg  [N-1:0] pol_ff;
    reg  [1:0]   irq_stat_ff;
    reg  [1:0]   irq_en_ff;
    // axi write capture
    reg          aw_got_ff;
    reg          w_got_ff;
    reg  [7:0]   aw_addr_ff;
    reg  [31:0]  w_data_ff;
    reg  [3:0]   w_strb_ff;

    // merge a write word under byte strobes
    function [31:0] strb_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer b;
        begin
            strb_merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b])
                    strb_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    endfunction

    // clamp the period field to its legal span
    function [2:0] per_clamp;
        input [2:0] v;
        begin
            if (v < `AAS_PER_MIN)
                per_clamp = `AAS_PER_MIN;
            else if (v > `AAS_PER_MAX)
                per_clamp = `AAS_PER_MAX;
            else
                per_clamp = v;
        end
    endfunction

    // button edges, only from the second stage onward
    wire         acc_rise = acc_sy_ff[1] & ~acc_sy_ff[2];   // [R14]
    wire         rst_rise = rst_sy_ff[1] & ~rst_sy_ff[2];   // [R14]
    wire         tst_lvl  = tst_sy_ff[1];
    wire [1:0]   grp_lvl  = grp_sy_ff[3:2];
    // alarm in the active sense per channel
    wire [N-1:0] sense    = raw_ff ^ pol_ff;                // [R10]
    wire [N-1:0] new_al   = sense & ~alarm_ff;
    // write commit when both halves are in
    wire         wr_go    = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    wire         auto_on  = ctrl_ff[`AAS_CTL_AUTO_BIT];
    wire [2:0]   per_sel  = per_clamp(ctrl_ff[`AAS_CTL_PER_MSB:`AAS_CTL_PER_LSB]);
    wire         auto_hit = auto_on & (|unack_ff) & (auto_cnt_ff == MIN_CYC - 32'h1)
                            & (auto_min_ff == per_sel - 3'h1);
    wire [N-1:0] debounced;
    wire         ack_now  = acc_rise | auto_hit;            // [R03] [R06]
    // polarity word merged under strobes, cut to the channel count
    wire [31:0]  pol_merged = strb_merge({{(32-N){1'b0}}, pol_ff}, w_data_ff, w_strb_ff);

    integer i;
    integer j;

    // debounce each channel with its own counter
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : ch
            assign debounced[g] = (deb_cnt_ff[g] == DEB_CYC - 32'h1) & (sense[g] ^ alarm_ff[g]);
            always @(posedge clk_i) begin
                if (reset_i) begin
                    deb_cnt_ff[g] <= 32'h0;
                end else if (ce_i) begin
                    // count while sense differs, restart on any bounce
                    if (sense[g] == alarm_ff[g])
                        deb_cnt_ff[g] <= 32'h0;       // [R09]
                    else if (!debounced[g])
                        deb_cnt_ff[g] <= deb_cnt_ff[g] + 32'h1;
                    else
                        deb_cnt_ff[g] <= 32'h0;
                end
            end
        end
    endgenerate

    // sampling and button synchronisers
    always @(posedge clk_i) begin
        if (reset_i) begin
            raw_ff    <= {N{1'b0}};
            acc_sy_ff <= 3'h0;
            rst_sy_ff <= 3'h0;
            tst_sy_ff <= 2'h0;
            grp_sy_ff <= 4'h0;
        end else if (ce_i) begin
            raw_ff    <= contact_i;
            acc_sy_ff <= {acc_sy_ff[1:0], accept_pb_i};
            rst_sy_ff <= {rst_sy_ff[1:0], reset_pb_i};
            tst_sy_ff <= {tst_sy_ff[0], test_pb_i};
            grp_sy_ff <= {grp_sy_ff[1:0], group_test_i};
        end
    end

    // alarm sequence per channel, same logic for spares
    always @(posedge clk_i) begin
        if (reset_i) begin
            alarm_ff   <= {N{1'b0}};
            unack_ff   <= {N{1'b0}};
            latched_ff <= {N{1'b0}};
        end else if (ce_i) begin
            for (i = 0; i < N; i = i + 1) begin     // [R12]
                if (debounced[i])
                    alarm_ff[i] <= ~alarm_ff[i];    // [R09]
                if (debounced[i] && !alarm_ff[i]) begin
                    // new alarm wins over accept in the same cycle
                    unack_ff[i]   <= 1'b1;          // [R01] [R05]
                    latched_ff[i] <= 1'b1;
                end else begin
                    if (ack_now)
                        unack_ff[i] <= 1'b0;        // [R03] [R07]
                    if (rst_rise && !alarm_ff[i] && !unack_ff[i])
                        latched_ff[i] <= 1'b0;      // [R04]
                end
            end
        end
    end

    // flash toggle at a fixed rate
    always @(posedge clk_i) begin
        if (reset_i) begin
            flash_cnt_ff <= 32'h0;
            flash_ff     <= 1'b0;
        end else if (ce_i) begin
            if (flash_cnt_ff == HALF_CYC - 32'h1) begin
                flash_cnt_ff <= 32'h0;
                flash_ff     <= ~flash_ff;          // [R02]
            end else begin
                flash_cnt_ff <= flash_cnt_ff + 32'h1;
            end
        end
    end

    // auto-accept timer, restarted by every new alarm
    always @(posedge clk_i) begin
        if (reset_i) begin
            auto_cnt_ff <= 32'h0;
            auto_min_ff <= 3'h0;
        end else if (ce_i) begin
            if (!auto_on || !(|unack_ff) || (|(new_al & debounced)) || auto_hit) begin
                auto_cnt_ff <= 32'h0;
                auto_min_ff <= 3'h0;
            end else if (auto_cnt_ff == MIN_CYC - 32'h1) begin
                auto_cnt_ff <= 32'h0;
                auto_min_ff <= auto_min_ff + 3'h1;  // [R06]
            end else begin
                auto_cnt_ff <= auto_cnt_ff + 32'h1;
            end
        end
    end

    // lamp and horn outputs; test touches no alarm state
    always @(posedge clk_i) begin
        if (reset_i) begin
            lamp_o <= {N{1'b0}};
            horn_o <= 1'b0;
        end else if (ce_i) begin
            for (j = 0; j < N; j = j + 1) begin
                lamp_o[j] <= tst_lvl | grp_lvl[j / HALF]                    // [R08] [R13]
                             | (unack_ff[j] ? flash_ff : latched_ff[j]);    // [R01] [R03]
            end
            horn_o <= (|unack_ff) | tst_lvl;        // [R14] [R08]
        end
    end

    // interrupt status, set wins over clear
    always @(posedge clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= 2'h0;
            irq_o       <= 1'b0;
        end else if (ce_i) begin
            irq_stat_ff <= (irq_stat_ff
                           & ~((wr_go && aw_addr_ff == `AAS_A_IRQ_CLR) ? w_data_ff[1:0] : 2'h0))
                           | {auto_hit, |(new_al & debounced)};
            irq_o       <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // axi write channel, address and data in either order
    always @(posedge clk_i) begin
        if (reset_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AAS_RESP_OK;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            aw_addr_ff    <= 8'h0;
            w_data_ff     <= 32'h0;
            w_strb_ff     <= 4'h0;
            ctrl_ff       <= `AAS_CTL_RST_VAL;
            pol_ff        <= {N{1'b0}};
            irq_en_ff     <= 2'h0;
        end else if (ce_i) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_ff    <= s_axi_awaddr;
                aw_got_ff     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_ff    <= s_axi_wdata;
                w_strb_ff    <= s_axi_wstrb;
                w_got_ff     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `AAS_RESP_OK;
                case (aw_addr_ff)
                    `AAS_A_CTRL: ctrl_ff <= strb_merge(ctrl_ff, w_data_ff, w_strb_ff);
                    `AAS_A_POL:  pol_ff <= pol_merged[N-1:0];   // [R10]
                    `AAS_A_IRQ_EN: irq_en_ff <= w_data_ff[1:0];
                    `AAS_A_IRQ_CLR: ;
                    default: s_axi_bresp <= `AAS_RESP_ERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_ff     <= 1'b0;
                w_got_ff      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // axi read channel
    always @(posedge clk_i) begin
        if (reset_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `AAS_RESP_OK;
        end else if (ce_i) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `AAS_RESP_OK;
                case (s_axi_araddr)
                    `AAS_A_CTRL:     s_axi_rdata <= ctrl_ff;
                    `AAS_A_POL:      s_axi_rdata <= {{(32-N){1'b0}}, pol_ff};
                    `AAS_A_STAT:     s_axi_rdata <= {{(32-2*N){1'b0}}, unack_ff, alarm_ff};
                    `AAS_A_LAMP:     s_axi_rdata <= {{(32-N){1'b0}}, latched_ff};
                    `AAS_A_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_ff};
                    `AAS_A_IRQ_EN:   s_axi_rdata <= {30'h0, irq_en_ff};
                    `AAS_A_IRQ_CLR:  s_axi_rdata <= 32'h0;
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `AAS_RESP_ERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/aas_annunciator_assertions.sv ====
`include "aas_defines.vh"
`default_nettype none
// port watcher for the annunciator
module aas_chk #(
    parameter [31:0] DEB_CYC = 8
) (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire logic [`AAS_NCH-1:0] contact_i,
    input wire logic                accept_pb_i,
    input wire logic                test_pb_i,
    input wire logic [1:0]          group_test_i,
    input wire logic [`AAS_NCH-1:0] lamp_o,
    input wire logic                horn_o,
    input wire logic                irq_o,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid
);
    logic [`AAS_NCH-1:0] prev_ff;  // contacts one cycle back
    logic [3:0]          quiet_ff; // cycles since contacts moved
    logic [7:0]          tst_ff;   // recent lamp test history
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // history and saturating quiet count
    always @(posedge clk_i) begin
        prev_ff <= contact_i;
        tst_ff  <= {tst_ff[6:0], test_pb_i | group_test_i[0]};
        if (reset_i || contact_i != prev_ff) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hF) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    a_debounce_hold: assert property (
        $rose(horn_o) && tst_ff == 8'h00 |-> quiet_ff >= DEB_CYC - 1)
        else $error("horn rose before contacts settled");
    a_test_lamps: assert property (
        test_pb_i [*6] |-> &lamp_o && horn_o)
        else $error("test did not light all lamps and horn");
    a_group_low: assert property (
        group_test_i[0] [*6] |-> &lamp_o[5:0])
        else $error("low group test lamps dark");
    a_group_high: assert property (
        group_test_i[1] [*6] |-> &lamp_o[11:6])
        else $error("high group test lamps dark");
    a_accept_quiets: assert property (
        $rose(accept_pb_i) ##1 (!test_pb_i && $stable(contact_i)) [*6] |-> !horn_o)
        else $error("horn still on after accept");
    a_flash_off: assert property (
        $fell(lamp_o[0]) && horn_o && tst_ff == 8'h00 |=> (!lamp_o[0] || !horn_o) [*3])
        else $error("flash off phase too short");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_reset_quiet: assert property (
        $fell(reset_i) |-> !(|lamp_o) && !horn_o && !irq_o && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active after reset");
endmodule
bind aas_annunciator aas_chk #(.DEB_CYC(DEB_CYC)) u_chk (
    .clk_i, .reset_i, .contact_i, .accept_pb_i, .test_pb_i, .group_test_i, .lamp_o,
    .horn_o, .irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// ==== sim/aas_field.sv ====
`include "aas_defines.vh"
`default_nettype none
// field contacts: level per channel, wired to chosen sense
module aas_field (
    input  wire logic                clk_i,
    input  wire logic [`AAS_NCH-1:0] alarm_i, // wanted alarm per channel
    input  wire logic [`AAS_NCH-1:0] pol_i,   // 1: contact low means alarm
    input  wire logic [`AAS_NCH-1:0] blip_i,  // brief transient overlay
    output var  logic [`AAS_NCH-1:0] contact_o
);
    initial contact_o = 12'h000;
    // contact held for the whole alarm
    always @(posedge clk_i) begin
        contact_o <= alarm_i ^ pol_i ^ blip_i;
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`include "aas_defines.vh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEB = 8;
    localparam int HALF = 4;
    localparam int MINC = 20;
    logic                clk_i = 1'h0;
    logic                reset_i = 1'h1;
    logic                ce_i = 1'h1; // enable on, dropped once for the hold check
    logic                accept_pb_i = 1'h0;
    logic                reset_pb_i = 1'h0;
    logic                test_pb_i = 1'h0;
    logic                b;
    logic [1:0]          group_test_i = 2'h0;
    logic [`AAS_NCH-1:0] contact_i, lamp_o;
    logic [`AAS_NCH-1:0] alarm = 12'h000, pol = 12'h000, blip = 12'h000;
    logic                horn_o, irq_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                s_axi_arready, s_axi_rvalid;
    logic                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic                s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]         s_axi_wdata = 32'h0, s_axi_rdata, rnd;
    logic [3:0]          s_axi_wstrb = 4'h0;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    int                  num_errors = 0, comparisons = 0, ch;
    aas_annunciator #(.DEB_CYC(DEB), .HALF_CYC(HALF), .MIN_CYC(MINC)) uut (
        .clk_i, .reset_i, .ce_i, .contact_i, .accept_pb_i, .reset_pb_i, .test_pb_i,
        .group_test_i, .lamp_o, .horn_o, .irq_o, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    aas_field fld (.clk_i, .alarm_i(alarm), .pol_i(pol), .blip_i(blip), .contact_o(contact_i));
    initial forever #25 clk_i = ~clk_i;
    // compare and count
    task chk(input [31:0] got, input [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // bus write, both channels offered together
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
        @(posedge clk_i);
    endtask
    // bus read with expected data and response
    task rdc(input [7:0] a, input [31:0] ed, input [1:0] er);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        @(posedge clk_i);
    endtask
    // 0 accept, 1 reset button
    task press(input int w);
        if (w == 0) accept_pb_i <= 1'h1;
        else reset_pb_i <= 1'h1;
        tick(3);
        accept_pb_i <= 1'h0;
        reset_pb_i <= 1'h0;
        tick(6);
    endtask
    function [31:0] stat_exp(input [11:0] al, input [11:0] un);
        return {8'h00, un, al};
    endfunction
    task end_of_test;
        $display("num_errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(3000 * 50);
        num_errors++;
        end_of_test;
    end
    initial begin
        rnd = $urandom(32'hAA5A);
        tick(6);
        reset_i <= 1'h0;
        tick(1);
        rdc(`AAS_A_CTRL, `AAS_CTL_RST_VAL, `AAS_RESP_OK);
        rdc(`AAS_A_STAT, 32'h0, `AAS_RESP_OK);
        rdc(`AAS_A_IRQ_CLR, 32'h0, `AAS_RESP_OK);
        rdc(8'h1C, 32'h0, `AAS_RESP_ERR);
        wr(8'h1C, 32'hFFFF, `AAS_RESP_ERR);
        // random sense and a spare-inclusive channel
        ch = 1 + $urandom % 11;
        rnd = $urandom & 32'hFFF;
        wr(`AAS_A_POL, rnd, `AAS_RESP_OK);
        pol <= rnd[11:0];
        rdc(`AAS_A_POL, rnd, `AAS_RESP_OK);
        blip[ch] <= 1'h1;
        tick(1 + $urandom % (DEB - 2));
        blip <= 12'h000;
        tick(DEB + 4);
        rdc(`AAS_A_STAT, 32'h0, `AAS_RESP_OK);
        alarm[ch] <= 1'h1;
        tick(DEB + 5);
        chk(horn_o, 1);
        rdc(`AAS_A_STAT, stat_exp(alarm, alarm), `AAS_RESP_OK);
        chk(irq_o, 0);
        press(0);
        chk(horn_o, 0);
        for (int i = 0; i <= HALF; i++) begin
            chk(lamp_o[ch], 1);
            tick(1);
        end
        // further alarm on channel zero while one stands accepted
        alarm[0] <= 1'h1;
        tick(DEB + 5);
        chk(horn_o, 1);
        b = lamp_o[0];
        tick(HALF);
        chk(lamp_o[0], !b);
        chk(lamp_o[ch], 1);
        tick(HALF);
        chk(lamp_o[0], b);
        // enable low: flash, horn and lamps must hold still
        ce_i <= 1'h0;
        tick(1);
        b = lamp_o[0];
        tick(3 * HALF);
        chk(lamp_o[0], b);
        chk(horn_o, 1);
        ce_i <= 1'h1;
        wr(`AAS_A_IRQ_EN, 32'h1, `AAS_RESP_OK);
        tick(2);
        chk(irq_o, 1);
        wr(`AAS_A_IRQ_CLR, 32'h1, `AAS_RESP_OK);
        tick(2);
        chk(irq_o, 0);
        press(0);
        press(1);
        chk(lamp_o, alarm);
        alarm <= 12'h000;
        tick(DEB + 5);
        chk(lamp_o, 12'h001 << ch | 12'h001);
        press(1);
        chk(lamp_o, 0);
        test_pb_i <= 1'h1;
        tick(8);
        chk(lamp_o, 12'hFFF);
        chk(horn_o, 1);
        test_pb_i <= 1'h0;
        tick(6);
        chk(horn_o, 0);
        rdc(`AAS_A_STAT, 32'h0, `AAS_RESP_OK);
        for (int g = 0; g < 2; g++) begin
            group_test_i <= 2'h1 << g;
            tick(8);
            chk(lamp_o, 12'h03F << (6 * g));
            group_test_i <= 2'h0;
            tick(6);
        end
        // auto accept with a two-unit period
        wr(`AAS_A_CTRL, 32'h5, `AAS_RESP_OK);
        alarm[ch] <= 1'h1;
        tick(DEB + 5);
        chk(horn_o, 1);
        tick(MINC + 5);
        chk(horn_o, 1);
        tick(MINC);
        chk(horn_o, 0);
        rdc(`AAS_A_STAT, stat_exp(alarm, 12'h000), `AAS_RESP_OK);
        rdc(`AAS_A_IRQ_STAT, 32'h3, `AAS_RESP_OK);
        end_of_test;
    end
endmodule
`default_nettype wire
